/* File: logic/pin_mux_pkg.sv */
// Constants for the shared pin multiplexer and port logic.
// Assumes a 16-bit data-space bus with one-cycle read and write strobes.
package pin_mux_pkg;
    localparam logic [15:0] sel_addr = 16'h7090;
    localparam logic [15:0] pa_addr = 16'h7098;
    localparam logic [15:0] pb_addr = 16'h709a;
    localparam logic [15:0] sel_reset = 16'h0000;
    localparam logic [7:0] byte_reset = 8'h00;
    localparam int port_w = 8;
    localparam int pa_sel_lsb = 0;
    localparam int pb_sel_lsb = 8;
    localparam int dir_lsb = 8;
    localparam logic [15:0] rdata_reset = 16'h0000;
    localparam logic pin_reset = 1'h0;
    localparam logic fault_reset = 1'h1;
endpackage

/* File: logic/shared_pin_mux_gpio.sv */
// Shared pin multiplexer with two 8-bit general-purpose ports.
// Assumes pin inputs and bus signals are synchronous to clk.
`timescale 1ns/1ps
module shared_pin_mux_gpio
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    input wire logic [7:0] pa_pin_in,
    output logic [7:0] pa_pin_out,
    output logic [7:0] pa_pin_oe,
    input wire logic [7:0] pb_pin_in,
    output logic [7:0] pb_pin_out,
    output logic [7:0] pb_pin_oe,
    input wire logic [7:0] pa_periph_out,
    input wire logic [7:0] pa_periph_oe,
    input wire logic [7:0] pb_periph_out,
    input wire logic [7:0] pb_periph_oe,
    output logic [7:0] pa_periph_in,
    output logic [7:0] pb_periph_in,
    output logic power_drive_protect_input
);

    logic [15:0] pin_function_select_r;
    logic [7:0] pa_data_r;
    logic [7:0] pa_dir_r;
    logic [7:0] pb_data_r;
    logic [7:0] pb_dir_r;
    logic [7:0] pa_sel;
    logic [7:0] pb_sel;
    logic [15:0] rdata_nxt;

    assign pa_sel = pin_function_select_r[pa_sel_lsb +: port_w];
    assign pb_sel = pin_function_select_r[pb_sel_lsb +: port_w];

    // Select register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_function_select_r <= sel_reset;
        end else if (bus_wr && bus_addr == sel_addr) begin
            pin_function_select_r <= bus_wdata;
        end
    end

    sequence s_sel_write;
        bus_wr && bus_addr == sel_addr;
    endsequence

    property p_sel_write;
        @(posedge clk) disable iff (!rst_b)
        s_sel_write |=> pin_function_select_r == $past(bus_wdata);
    endproperty
    a_sel_write: assert property (p_sel_write)
        else $error("select write lost");

    property p_sel_hold;
        @(posedge clk) disable iff (!rst_b)
        !(bus_wr && bus_addr == sel_addr)
            |=> $stable(pin_function_select_r);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("select changed");

    // Port data and direction registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pa_data_r <= byte_reset;
            pa_dir_r <= byte_reset;
            pb_data_r <= byte_reset;
            pb_dir_r <= byte_reset;
        end else if (bus_wr) begin
            if (bus_addr == pa_addr) begin
                pa_data_r <= bus_wdata[port_w-1:0];
                pa_dir_r <= bus_wdata[dir_lsb +: port_w];
            end
            if (bus_addr == pb_addr) begin
                pb_data_r <= bus_wdata[port_w-1:0];
                pb_dir_r <= bus_wdata[dir_lsb +: port_w];
            end
        end
    end

    sequence s_pb_write;
        bus_wr && bus_addr == pb_addr;
    endsequence

    sequence s_pb_io_quiet;
        !bus_wr && pb_sel == 8'h00;
    endsequence

    property p_pa_reg_write;
        @(posedge clk) disable iff (!rst_b)
        (bus_wr && bus_addr == pa_addr)
            |=> {pa_dir_r, pa_data_r} == $past(bus_wdata);
    endproperty
    a_pa_reg_write: assert property (p_pa_reg_write)
        else $error("port a store");

    property p_pb_reg_write;
        @(posedge clk) disable iff (!rst_b)
        s_pb_write |=> {pb_dir_r, pb_data_r} == $past(bus_wdata);
    endproperty
    a_pb_reg_write: assert property (p_pb_reg_write)
        else $error("port b store");

    property p_pb_write_drive;
        logic [15:0] w;
        @(posedge clk) disable iff (!rst_b)
        (s_pb_write, w = bus_wdata) ##1 s_pb_io_quiet
            |=> pb_pin_out == w[port_w-1:0]
                && pb_pin_oe == w[dir_lsb +: port_w];
    endproperty
    a_pb_write_drive: assert property (p_pb_write_drive)
        else $error("port b drive");

    // Read data: input pins show pin level, outputs show stored data
    always_comb begin
        rdata_nxt = rdata_reset;
        if (bus_addr == sel_addr) begin
            rdata_nxt = pin_function_select_r;
        end else if (bus_addr == pa_addr) begin
            rdata_nxt = {pa_dir_r,
                (pa_dir_r & pa_data_r) | (~pa_dir_r & pa_pin_in)};
        end else if (bus_addr == pb_addr) begin
            rdata_nxt = {pb_dir_r,
                (pb_dir_r & pb_data_r) | (~pb_dir_r & pb_pin_in)};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata <= rdata_reset;
        end else if (bus_rd) begin
            bus_rdata <= rdata_nxt;
        end
    end

    property p_rdata_hold;
        @(posedge clk) disable iff (!rst_b)
        !bus_rd |=> $stable(bus_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved");

    property p_sel_read;
        @(posedge clk) disable iff (!rst_b)
        (bus_rd && bus_addr == sel_addr)
            |=> bus_rdata == $past(pin_function_select_r);
    endproperty
    a_sel_read: assert property (p_sel_read)
        else $error("select read");

    property p_hole_read;
        @(posedge clk) disable iff (!rst_b)
        (bus_rd && bus_addr != sel_addr && bus_addr != pa_addr
            && bus_addr != pb_addr) |=> bus_rdata == rdata_reset;
    endproperty
    a_hole_read: assert property (p_hole_read)
        else $error("unmapped read");

    // Pin drivers, one per pin of each port
    genvar i;
    generate
        for (i = 0; i < port_w; i++) begin : g_pin
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    pa_pin_out[i] <= pin_reset;
                    pa_pin_oe[i] <= pin_reset;
                    pb_pin_out[i] <= pin_reset;
                    pb_pin_oe[i] <= pin_reset;
                    pa_periph_in[i] <= pin_reset;
                    pb_periph_in[i] <= pin_reset;
                end else begin
                    if (pa_sel[i]) begin
                        pa_pin_out[i] <= pa_periph_out[i];
                        pa_pin_oe[i] <= pa_periph_oe[i];
                    end else begin
                        pa_pin_out[i] <= pa_data_r[i];
                        pa_pin_oe[i] <= pa_dir_r[i];
                    end
                    if (pb_sel[i]) begin
                        pb_pin_out[i] <= pb_periph_out[i];
                        pb_pin_oe[i] <= pb_periph_oe[i];
                    end else begin
                        pb_pin_out[i] <= pb_data_r[i];
                        pb_pin_oe[i] <= pb_dir_r[i];
                    end
                    pa_periph_in[i] <= pa_sel[i] & pa_pin_in[i];
                    pb_periph_in[i] <= pb_sel[i] & pb_pin_in[i];
                end
            end

            property p_pa_io_drive;
                @(posedge clk) disable iff (!rst_b)
                !pa_sel[i] |=> pa_pin_out[i] == $past(pa_data_r[i])
                    && pa_pin_oe[i] == $past(pa_dir_r[i]);
            endproperty
            a_pa_io_drive: assert property (p_pa_io_drive)
                else $error("port a io drive");

            property p_pa_periph;
                @(posedge clk) disable iff (!rst_b)
                pa_sel[i] |=> pa_pin_out[i] == $past(pa_periph_out[i])
                    && pa_pin_oe[i] == $past(pa_periph_oe[i]);
            endproperty
            a_pa_periph: assert property (p_pa_periph)
                else $error("port a periph drive");

            property p_pb_periph;
                @(posedge clk) disable iff (!rst_b)
                pb_sel[i] |=> pb_pin_out[i] == $past(pb_periph_out[i])
                    && pb_pin_oe[i] == $past(pb_periph_oe[i]);
            endproperty
            a_pb_periph: assert property (p_pb_periph)
                else $error("port b periph drive");

            property p_pa_periph_in;
                @(posedge clk) disable iff (!rst_b)
                pa_sel[i] |=> pa_periph_in[i] == $past(pa_pin_in[i]);
            endproperty
            a_pa_periph_in: assert property (p_pa_periph_in)
                else $error("port a periph input");

            property p_pb_periph_in;
                @(posedge clk) disable iff (!rst_b)
                pb_sel[i] |=> pb_periph_in[i] == $past(pb_pin_in[i]);
            endproperty
            a_pb_periph_in: assert property (p_pb_periph_in)
                else $error("port b periph input");

            property p_pa_periph_quiet;
                @(posedge clk) disable iff (!rst_b)
                !pa_sel[i] |=> !pa_periph_in[i];
            endproperty
            a_pa_periph_quiet: assert property (p_pa_periph_quiet)
                else $error("port a periph not quiet");

            property p_pb_in_read;
                @(posedge clk) disable iff (!rst_b)
                (bus_rd && bus_addr == pb_addr && !pb_dir_r[i])
                    |=> bus_rdata[i] == $past(pb_pin_in[i]);
            endproperty
            a_pb_in_read: assert property (p_pb_in_read)
                else $error("port b pin read");
        end
    endgenerate

    // Drive fault input always watches port A pin 0
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_drive_protect_input <= fault_reset;
        end else begin
            power_drive_protect_input <= pa_pin_in[0];
        end
    end

    property p_sel_reset;
        @(posedge clk) $rose(rst_b) |-> pin_function_select_r == sel_reset;
    endproperty
    a_sel_reset: assert property (p_sel_reset)
        else $error("select not clear");

    property p_periph_route;
        @(posedge clk) disable iff (!rst_b)
        pa_sel[1] |=> pa_pin_out[1] == $past(pa_periph_out[1]);
    endproperty
    a_periph_route: assert property (p_periph_route)
        else $error("periph route");

    property p_input_off;
        @(posedge clk) disable iff (!rst_b)
        (!pb_sel[2] && !pb_dir_r[2]) |=> !pb_pin_oe[2];
    endproperty
    a_input_off: assert property (p_input_off)
        else $error("driver not off");

    property p_read_pin;
        @(posedge clk) disable iff (!rst_b)
        (bus_rd && bus_addr == pa_addr && !pa_dir_r[3])
            |=> bus_rdata[3] == $past(pa_pin_in[3]);
    endproperty
    a_read_pin: assert property (p_read_pin)
        else $error("pin read wrong");

    sequence s_write_pa;
        bus_wr && bus_addr == pa_addr && pa_sel == 8'h00;
    endsequence
    property p_write_drive;
        logic [15:0] w;
        @(posedge clk) disable iff (!rst_b)
        (s_write_pa, w = bus_wdata) ##1 !bus_wr
            |=> pa_pin_out == w[port_w-1:0]
                && pa_pin_oe == w[dir_lsb +: port_w];
    endproperty
    a_write_drive: assert property (p_write_drive)
        else $error("drive wrong");

    property p_periph_oe;
        @(posedge clk) disable iff (!rst_b)
        pb_sel[3] |=> pb_pin_oe[3] == $past(pb_periph_oe[3]);
    endproperty
    a_periph_oe: assert property (p_periph_oe)
        else $error("oe not periph");

    property p_fault;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> power_drive_protect_input == $past(pa_pin_in[0]);
    endproperty
    a_fault: assert property (p_fault)
        else $error("fault not tracked");

    property p_pb_read;
        @(posedge clk) disable iff (!rst_b)
        (bus_rd && bus_addr == pb_addr)
            |=> bus_rdata[15:8] == $past(pb_dir_r);
    endproperty
    a_pb_read: assert property (p_pb_read)
        else $error("pb dir read");

endmodule

/* File: bench/pin_side.sv */
// Far side model: pads with external levels.
// Assumes a pad shows the device drive while its enable is high.
`timescale 1ns/1ps
module pin_side(
    input wire logic [7:0] drv,
    input wire logic [7:0] en,
    input wire logic [7:0] ext,
    output logic [7:0] lvl
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl[i] = en[i] ? drv[i] : ext[i];
        end
    end
endmodule

/* File: bench/tb.sv */
// Testbench for the shared pin multiplexer.
// Assumes one-cycle strobes and registered outputs.
`timescale 1ns/1ps
module tb;
    import pin_mux_pkg::*;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, pdp;
    logic [15:0] ad = 16'h0000, wd = 16'h0000, q, v;
    logic [7:0] ea = 8'h00, eb = 8'h00, pai, pbi, pao, pbo, pae, pbe;
    logic [7:0] po = 8'h00, pe = 8'h00, pfa, pfb;
    int n_errors = 0, checked = 0;
    always #12.5 clk = ~clk;
    shared_pin_mux_gpio dut_u(.clk(clk), .rst_b(rst_b), .bus_addr(ad),
        .bus_wr(wr), .bus_rd(rd), .bus_wdata(wd), .bus_rdata(q),
        .pa_pin_in(pai), .pa_pin_out(pao), .pa_pin_oe(pae),
        .pb_pin_in(pbi), .pb_pin_out(pbo), .pb_pin_oe(pbe),
        .pa_periph_out(po), .pa_periph_oe(pe), .pb_periph_out(~po),
        .pb_periph_oe(pe), .pa_periph_in(pfa), .pb_periph_in(pfb),
        .power_drive_protect_input(pdp));
    pin_side side_a(.drv(pao), .en(pae), .ext(ea), .lvl(pai));
    pin_side side_b(.drv(pbo), .en(pbe), .ext(eb), .lvl(pbi));
    task chk(string n, logic [15:0] s, logic [15:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task wrr(logic [15:0] a, logic [15:0] d);
        @(negedge clk);
        ad = a;
        wd = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
        repeat (2) @(negedge clk);
    endtask
    task rdr(logic [15:0] a);
        @(negedge clk);
        ad = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        @(negedge clk);
        v = q;
    endtask
    task t_io();
        rdr(sel_addr);
        chk("sel", v, 16'h0000);
        chk("oe", {pae, pbe}, 16'h0000);
        wrr(pa_addr, 16'hffa5);
        chk("pa", {pae, pao}, 16'hffa5);
        rdr(pa_addr);
        chk("pa rd", v, 16'hffa5);
        ea = 8'h3c;
        wrr(pa_addr, 16'h0f05);
        rdr(pa_addr);
        chk("pa mix", v, 16'h0f35);
        wrr(pa_addr, 16'h0000);
        ea = 8'h01;
        rdr(sel_addr);
        chk("pdp1", pdp, 1'b1);
        ea = 8'h00;
        rdr(sel_addr);
        chk("pdp0", pdp, 1'b0);
        $display("test io done");
    endtask
    task t_mux();
        wrr(pa_addr, 16'hffa5);
        po = 8'h5a;
        pe = 8'hf0;
        ea = 8'h03;
        wrr(sel_addr, 16'h00ff);
        chk("pa oe", pae, 8'hf0);
        chk("pa out", pao & pae, 8'h50);
        chk("pa in", pfa, 8'h53);
        chk("pb in", pfb, 8'h00);
        chk("pdp", pdp, 1'b1);
        wrr(sel_addr, 16'h0000);
        wrr(pb_addr, 16'h3f15);
        chk("pb", {pbe, pbo}, 16'h3f15);
        eb = 8'h0c;
        wrr(sel_addr, 16'h3f00);
        chk("pb oe", pbe, 8'h30);
        chk("pb out", pbo, 8'h25);
        chk("pb in", pfb, 8'h2c);
        chk("pa back", {pae, pao}, 16'hffa5);
        $display("test mux done");
    endtask
    task t_map();
        wrr(16'h7092, 16'hffff);
        rdr(16'h7092);
        chk("hole", v, 16'h0000);
        rdr(pb_addr);
        chk("pb rd", v[13:8], 6'h3f);
        chk("pb data", v[7:0], 8'h15);
        rdr(sel_addr);
        chk("sel rd", v, 16'h3f00);
        $display("test map done");
    endtask
    task t_reset();
        wrr(sel_addr, 16'h00ff);
        chk("pre oe", pae, 8'hf0);
        @(negedge clk);
        rst_b = 0;
        @(negedge clk);
        rst_b = 1;
        chk("rst oe", {pae, pbe}, 16'h0000);
        rdr(sel_addr);
        chk("rst sel", v, 16'h0000);
        chk("rst pa in", pfa, 8'h00);
        rdr(pa_addr);
        chk("rst pa rd", v, 16'h0003);
        $display("test reset done");
    endtask
    task summarize();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst_b = 1;
        t_io();
        t_mux();
        t_map();
        t_reset();
        summarize();
    end
endmodule
